// file: src/scu_pkg.sv
// Types of the clock configuration unit.
// Assumes the register map header for all numeric values.
package scu_pkg;
  typedef enum logic [1:0] {SCU_OFF, SCU_FULL, SCU_HALF, SCU_THIRD} scu_ratio_e;
  typedef enum logic [1:0] {SCU_LB_DIV2, SCU_LB_DIV4, SCU_LB_DIV8, SCU_LB_RSVD} scu_lbdiv_e;
  typedef struct packed {
    logic [1:0] cnt;
    logic tick;
  } scu_unit_s;
  typedef struct packed {
    logic [2:0] strap_s;
    logic [1:0] cfg_wait;
    logic cfg_done;
    logic host;
    logic strap;
    logic [31:0] reset_config_word_low;
    logic [31:0] reset_config_word_high;
    logic [2:0] output_clock_control_reg;
    logic [7:0] system_clock_control_reg;
    scu_lbdiv_e local_bus_clock_ratio_reg;
    logic [2:0] en_act;
    logic [1:0] base;
    logic [2:0] lb_cnt;
    logic sync_out;
    logic [2:0] bus_clk;
    logic memory_bus_clock;
    logic mck_n;
    logic local_bus_clock_out;
    logic system_pll_multiplier_bad;
    logic [3:0] csb_ratio;
    logic [4:0] mem_ratio;
    logic [4:0] lbc_ratio;
    logic [6:0] core_ratio;
    logic [4:0] eng_mult;
    logic [1:0] eng_div;
    logic [3:0] unit_en;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } scu_state_s;
endpackage

// file: src/scu_regs.svh
// Register offsets, config word field positions and reset values of the
// clock configuration unit. Assumes a 32-bit AXI4-Lite window, 8-bit address.
`ifndef SCU_REGS_SVH
`define SCU_REGS_SVH
`define SCU_OUTPUT_CLOCK_CONTROL_REG_OFS 8'h00
`define SCU_SYSTEM_CLOCK_CONTROL_REG_OFS 8'h04
`define SCU_LOCAL_BUS_CLOCK_RATIO_REG_OFS 8'h08
`define SCU_STAT_OFS 8'h0C
`define SCU_RESET_CONFIG_WORD_LOW_OFS 8'h10
`define SCU_RESET_CONFIG_WORD_HIGH_OFS 8'h14
`define SCU_OUTPUT_CLOCK_CONTROL_REG_RST 3'h0
`define SCU_SYSTEM_CLOCK_CONTROL_REG_RST 8'h55
`define SCU_SYSTEM_PLL_MULTIPLIER_LSB 0
`define SCU_SYSTEM_PLL_MULTIPLIER_MSB 3
`define SCU_CORE_LSB 4
`define SCU_CORE_MSB 10
`define SCU_ENGINE_PLL_MULTIPLIER_LSB 11
`define SCU_ENGINE_PLL_MULTIPLIER_MSB 15
`define SCU_ENGINE_PLL_DIVISION_BIT 16
`define SCU_LOCAL_BUS_CLOCK_MODE_BIT 17
`define SCU_HOST_BIT 0
`define SCU_SYSTEM_PLL_MULTIPLIER_MIN 4'h2
`define SCU_SYSTEM_PLL_MULTIPLIER_MAX 4'h6
`define SCU_SETTLE 2'h3
`define SCU_RESP_OKAY 2'h0
`define SCU_RESP_SLVERR 2'h2
`endif

// file: src/scu_top.sv
// Clock configuration unit: config word capture, bus clock gating, divided
// clock waveforms, clock ratio reporting and an AXI4-Lite register window.
// Assumes clk_i stands for the system clock input; divided clocks are
// flop-driven waveforms of it and ratios are reported as numbers.
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "scu_regs.svh"
module scu_top import scu_pkg::*; (
  input wire logic clk_i,                            // 125 MHz clock
  input wire logic rst_i,                            // Sync reset, active high
  input wire logic [31:0] reset_config_word_low_i,   // Low config word
  input wire logic [31:0] reset_config_word_high_i,  // High config word
  input wire logic input_halving_strap_i,            // Strap pin
  input wire logic [7:0] s_axi_awaddr_i,             // Write address
  input wire logic s_axi_awvalid_i,                  // Write address valid
  output logic s_axi_awready_o,                      // Write address ready
  input wire logic [31:0] s_axi_wdata_i,             // Write data
  input wire logic [3:0] s_axi_wstrb_i,              // Write strobes
  input wire logic s_axi_wvalid_i,                   // Write data valid
  output logic s_axi_wready_o,                       // Write data ready
  output logic [1:0] s_axi_bresp_o,                  // Write response
  output logic s_axi_bvalid_o,                       // Write response valid
  input wire logic s_axi_bready_i,                   // Write response ready
  input wire logic [7:0] s_axi_araddr_i,             // Read address
  input wire logic s_axi_arvalid_i,                  // Read address valid
  output logic s_axi_arready_o,                      // Read address ready
  output logic [31:0] s_axi_rdata_o,                 // Read data
  output logic [1:0] s_axi_rresp_o,                  // Read response
  output logic s_axi_rvalid_o,                       // Read data valid
  input wire logic s_axi_rready_i,                   // Read data ready
  output logic sync_clock_out_o,                     // Sync clock output
  output logic [2:0] bus_clock_out_o,                // Gated bus clocks
  output logic memory_bus_clock_o,                   // Memory clock
  output logic memory_bus_clock_n_o,                 // Memory clock, inverted
  output logic local_bus_clock_out_o,                // Local bus clock
  output logic [3:0] system_bus_ratio_o,             // Bus clock : sync in
  output logic [6:0] core_ratio_field_o,             // Core multiplier code
  output logic [4:0] memory_ctrl_ratio_o,            // Mem ctrl : sync in
  output logic [4:0] local_bus_ctrl_ratio_o,         // Local ctrl : sync in
  output logic [4:0] engine_pll_multiplier_o,        // Engine multiplier
  output logic [1:0] engine_pll_divisor_o,           // One plus division field
  output logic system_pll_reserved_o,                // Multiplier code reserved
  output logic host_mode_o,                          // Host mode active
  output logic config_done_o,                        // Config words caught
  output logic [3:0] unit_clock_enable_o             // Peripheral clock ticks
);
  scu_state_s q;
  scu_state_s d;
  logic [3:0] unit_tick;
  logic [3:0] system_pll_multiplier;
  logic [7:0] wa;
  logic [7:0] ra;
  logic [31:0] status;

  assign system_pll_multiplier = q.reset_config_word_low[`SCU_SYSTEM_PLL_MULTIPLIER_MSB:`SCU_SYSTEM_PLL_MULTIPLIER_LSB];
  assign wa = {s_axi_awaddr_i[7:2], 2'h0};
  assign ra = {s_axi_araddr_i[7:2], 2'h0};
  assign status = {9'h0, q.lbc_ratio, q.eng_div, q.eng_mult, q.csb_ratio, q.en_act,
                   q.system_pll_multiplier_bad, q.strap, q.host, q.cfg_done};

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral unit dividers
  for (genvar i = 0; i < 4; i++) begin : g_unit
    scu_unit_if u_if ();
    assign u_if.ratio = scu_ratio_e'(q.system_clock_control_reg[2*i+:2]);
    assign unit_tick[i] = u_if.tick;
    scu_unit_div u_div (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .port (u_if.unit)
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.strap_s = {q.strap_s[1:0], input_halving_strap_i};
    if (q.cfg_wait != `SCU_SETTLE) begin
      d.cfg_wait = q.cfg_wait + 2'h1;
    end
    // config words caught once the strap has settled
    if (!q.cfg_done && (q.cfg_wait == `SCU_SETTLE) && (q.strap_s[2] == q.strap_s[1])) begin
      d.cfg_done = 1'b1;
      d.strap = q.strap_s[2];
      d.reset_config_word_low = reset_config_word_low_i;
      d.reset_config_word_high = reset_config_word_high_i;
    end
    // host select bit picks the primary clock
    d.host = q.cfg_done & q.reset_config_word_high[`SCU_HOST_BIT];

    d.base = q.base + 2'h1;
    // one divider feeds both the sync and bus clock muxes
    // strap set passes the clock, clear halves it
    // agent mode keeps the sync and bus clock outputs quiet
    d.sync_out = q.host & (q.strap ? d.base[0] : d.base[1]);
    // enables move only in the low phase, so no runt pulse
    if (!d.sync_out) begin
      d.en_act = q.host ? q.output_clock_control_reg : 3'h0;
    end
    // one phase source for all bus clocks
    d.bus_clk = d.en_act & {3{d.sync_out}};

    d.memory_bus_clock = ~q.memory_bus_clock;
    d.mck_n = q.memory_bus_clock;

    d.lb_cnt = q.lb_cnt + 3'h1;
    unique case (q.local_bus_clock_ratio_reg)
      SCU_LB_DIV2: d.local_bus_clock_out = d.lb_cnt[0];
      SCU_LB_DIV4: d.local_bus_clock_out = d.lb_cnt[1];
      SCU_LB_DIV8, SCU_LB_RSVD: d.local_bus_clock_out = d.lb_cnt[2];
    endcase

    // only codes 2..6 give a factor
    d.system_pll_multiplier_bad = (system_pll_multiplier < `SCU_SYSTEM_PLL_MULTIPLIER_MIN) || (system_pll_multiplier > `SCU_SYSTEM_PLL_MULTIPLIER_MAX);
    // factor doubles unless the strap is set
    // reported ratios for each internal domain
    d.csb_ratio = d.system_pll_multiplier_bad ? 4'h0 : (q.strap ? system_pll_multiplier : {system_pll_multiplier[2:0], 1'b0});
    // memory controller at twice the bus clock
    d.mem_ratio = {d.csb_ratio, 1'b0};
    // local bus controller at one or two times
    d.lbc_ratio = q.reset_config_word_low[`SCU_LOCAL_BUS_CLOCK_MODE_BIT] ? {d.csb_ratio, 1'b0} : {1'b0, d.csb_ratio};
    // core multiplier handed to the core
    d.core_ratio = q.reset_config_word_low[`SCU_CORE_MSB:`SCU_CORE_LSB];
    d.eng_mult = q.reset_config_word_low[`SCU_ENGINE_PLL_MULTIPLIER_MSB:`SCU_ENGINE_PLL_MULTIPLIER_LSB];
    d.eng_div = {1'b0, q.reset_config_word_low[`SCU_ENGINE_PLL_DIVISION_BIT]} + 2'h1;
    // unit ticks registered to the pins
    d.unit_en = unit_tick;

    // Write channel: address and data are taken together
    d.awready = 1'b0;
    d.wready = 1'b0;
    if (q.bvalid && s_axi_bready_i) begin
      d.bvalid = 1'b0;
    end
    if (s_axi_awvalid_i && s_axi_wvalid_i && !q.bvalid && !q.awready) begin
      d.awready = 1'b1;
      d.wready = 1'b1;
      d.bvalid = 1'b1;
      d.bresp = `SCU_RESP_OKAY;
      case (wa)
        `SCU_OUTPUT_CLOCK_CONTROL_REG_OFS: d.output_clock_control_reg = s_axi_wstrb_i[0] ? s_axi_wdata_i[2:0] : q.output_clock_control_reg;
        // software writes the unit ratio before using the unit
        `SCU_SYSTEM_CLOCK_CONTROL_REG_OFS: d.system_clock_control_reg = s_axi_wstrb_i[0] ? s_axi_wdata_i[7:0] : q.system_clock_control_reg;
        `SCU_LOCAL_BUS_CLOCK_RATIO_REG_OFS: d.local_bus_clock_ratio_reg = s_axi_wstrb_i[0] ? scu_lbdiv_e'(s_axi_wdata_i[1:0]) : q.local_bus_clock_ratio_reg;
        // Config words and status are read-only; writes are dropped
        `SCU_STAT_OFS, `SCU_RESET_CONFIG_WORD_LOW_OFS, `SCU_RESET_CONFIG_WORD_HIGH_OFS: d.bresp = `SCU_RESP_OKAY;
        default: d.bresp = `SCU_RESP_SLVERR;
      endcase
    end

    // Read channel
    d.arready = 1'b0;
    if (q.rvalid && s_axi_rready_i) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && !q.rvalid && !q.arready) begin
      d.arready = 1'b1;
      d.rvalid = 1'b1;
      d.rresp = `SCU_RESP_OKAY;
      case (ra)
        `SCU_OUTPUT_CLOCK_CONTROL_REG_OFS: d.rdata = {29'h0, q.output_clock_control_reg};
        `SCU_SYSTEM_CLOCK_CONTROL_REG_OFS: d.rdata = {24'h0, q.system_clock_control_reg};
        `SCU_LOCAL_BUS_CLOCK_RATIO_REG_OFS: d.rdata = {30'h0, q.local_bus_clock_ratio_reg};
        `SCU_STAT_OFS: d.rdata = status;
        `SCU_RESET_CONFIG_WORD_LOW_OFS: d.rdata = q.reset_config_word_low;
        `SCU_RESET_CONFIG_WORD_HIGH_OFS: d.rdata = q.reset_config_word_high;
        default: begin
          d.rdata = 32'h0;
          d.rresp = `SCU_RESP_SLVERR;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.output_clock_control_reg <= `SCU_OUTPUT_CLOCK_CONTROL_REG_RST;
      q.system_clock_control_reg <= `SCU_SYSTEM_CLOCK_CONTROL_REG_RST;
      q.local_bus_clock_ratio_reg <= SCU_LB_DIV2;
      q.mck_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready_o = q.awready;
  assign s_axi_wready_o = q.wready;
  assign s_axi_bresp_o = q.bresp;
  assign s_axi_bvalid_o = q.bvalid;
  assign s_axi_arready_o = q.arready;
  assign s_axi_rdata_o = q.rdata;
  assign s_axi_rresp_o = q.rresp;
  assign s_axi_rvalid_o = q.rvalid;
  assign sync_clock_out_o = q.sync_out;
  assign bus_clock_out_o = q.bus_clk;
  assign memory_bus_clock_o = q.memory_bus_clock;
  assign memory_bus_clock_n_o = q.mck_n;
  assign local_bus_clock_out_o = q.local_bus_clock_out;
  assign system_bus_ratio_o = q.csb_ratio;
  assign core_ratio_field_o = q.core_ratio;
  assign memory_ctrl_ratio_o = q.mem_ratio;
  assign local_bus_ctrl_ratio_o = q.lbc_ratio;
  assign engine_pll_multiplier_o = q.eng_mult;
  assign engine_pll_divisor_o = q.eng_div;
  assign system_pll_reserved_o = q.system_pll_multiplier_bad;
  assign host_mode_o = q.host;
  assign config_done_o = q.cfg_done;
  assign unit_clock_enable_o = q.unit_en;

  ////////////////////////////////////////////////////////////////////////////
  property p_reset_low;
    @(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> (bus_clock_out_o == 3'h0) [*3];
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("bus clock active after reset");

  property p_off_low;
    @(posedge clk_i) disable iff (rst_i)
    (!q.output_clock_control_reg[0]) [*4] |-> !bus_clock_out_o[0];
  endproperty
  a_off_low: assert property (p_off_low) else $error("disabled bus clock toggles");

  property p_aligned;
    @(posedge clk_i) disable iff (rst_i)
    bus_clock_out_o[0] && q.en_act[2] |-> bus_clock_out_o[2] && sync_clock_out_o;
  endproperty
  a_aligned: assert property (p_aligned) else $error("bus clocks out of phase");

  property p_no_runt;
    @(posedge clk_i) disable iff (rst_i)
    $changed(bus_clock_out_o) |-> $changed(sync_clock_out_o);
  endproperty
  a_no_runt: assert property (p_no_runt) else $error("bus clock edge off the phase");

  property p_agent_quiet;
    @(posedge clk_i) disable iff (rst_i)
    q.cfg_done && !q.reset_config_word_high[`SCU_HOST_BIT] |=> !sync_clock_out_o && (bus_clock_out_o == 3'h0);
  endproperty
  a_agent_quiet: assert property (p_agent_quiet) else $error("clock output in agent mode");

  property p_sync_full;
    @(posedge clk_i) disable iff (rst_i)
    q.host && q.strap && sync_clock_out_o |=> !sync_clock_out_o;
  endproperty
  a_sync_full: assert property (p_sync_full) else $error("sync output not undivided");

  property p_sync_half;
    @(posedge clk_i) disable iff (rst_i)
    q.host && $past(q.host) && !q.strap && $rose(sync_clock_out_o)
      |=> sync_clock_out_o ##1 !sync_clock_out_o;
  endproperty
  a_sync_half: assert property (p_sync_half) else $error("sync output not halved");

  property p_csb_ratio;
    @(posedge clk_i) disable iff (rst_i)
    q.cfg_done && !q.strap && (system_pll_multiplier == 4'h6) |=> system_bus_ratio_o == 4'hC;
  endproperty
  a_csb_ratio: assert property (p_csb_ratio) else $error("bus clock ratio wrong");

  property p_system_pll_multiplier_rsvd;
    @(posedge clk_i) disable iff (rst_i)
    q.cfg_done && (system_pll_multiplier == 4'h7) |=> system_pll_reserved_o && (system_bus_ratio_o == 4'h0);
  endproperty
  a_system_pll_multiplier_rsvd: assert property (p_system_pll_multiplier_rsvd) else $error("reserved code not flagged");

  property p_mck_pair;
    @(posedge clk_i) disable iff (rst_i)
    memory_bus_clock_o |-> !memory_bus_clock_n_o ##1 !memory_bus_clock_o && memory_bus_clock_n_o;
  endproperty
  a_mck_pair: assert property (p_mck_pair) else $error("memory clock pair broken");

  property p_local_bus_clock_out_div4;
    @(posedge clk_i) disable iff (rst_i)
    (q.local_bus_clock_ratio_reg == SCU_LB_DIV4) [*3] ##0 $rose(local_bus_clock_out_o) |=> local_bus_clock_out_o;
  endproperty
  a_local_bus_clock_out_div4: assert property (p_local_bus_clock_out_div4) else $error("local bus clock high too short");

  property p_lbc_double;
    @(posedge clk_i) disable iff (rst_i)
    q.reset_config_word_low[`SCU_LOCAL_BUS_CLOCK_MODE_BIT] |-> local_bus_ctrl_ratio_o == {system_bus_ratio_o, 1'b0};
  endproperty
  a_lbc_double: assert property (p_lbc_double) else $error("local ctrl ratio not doubled");

  property p_unit_default;
    @(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> ##2 unit_clock_enable_o == 4'hF;
  endproperty
  a_unit_default: assert property (p_unit_default) else $error("units not at full rate");

  property p_host_sel;
    @(posedge clk_i) disable iff (rst_i)
    q.cfg_done && q.reset_config_word_high[`SCU_HOST_BIT] |=> host_mode_o;
  endproperty
  a_host_sel: assert property (p_host_sel) else $error("host select ignored");

  property p_bvalid_drop;
    @(posedge clk_i) disable iff (rst_i)
    s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o;
  endproperty
  a_bvalid_drop: assert property (p_bvalid_drop) else $error("write response repeated");

  property p_rvalid_drop;
    @(posedge clk_i) disable iff (rst_i)
    s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o;
  endproperty
  a_rvalid_drop: assert property (p_rvalid_drop) else $error("read response repeated");

  property p_aw_pulse;
    @(posedge clk_i) disable iff (rst_i)
    s_axi_awready_o |-> s_axi_wready_o && s_axi_bvalid_o ##1 !s_axi_awready_o;
  endproperty
  a_aw_pulse: assert property (p_aw_pulse) else $error("write ready not a pulse");

  c_bus_run: cover property (@(posedge clk_i) disable iff (rst_i) $rose(bus_clock_out_o[2]));
  c_local_bus_clock_out_div8: cover property (@(posedge clk_i) disable iff (rst_i)
    (q.local_bus_clock_ratio_reg == SCU_LB_DIV8) && $rose(local_bus_clock_out_o));
  c_unit_off: cover property (@(posedge clk_i) disable iff (rst_i)
    $fell(unit_clock_enable_o[3]));
endmodule // scu_top

// file: src/scu_unit_div.sv
// One peripheral unit clock divider: off, full, half or third rate ticks.
// Assumes the ratio comes from a register on the same clock.
`timescale 1ns/1ps
module scu_unit_div import scu_pkg::*; (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Sync reset, active high
  scu_unit_if.unit port   // Ratio in, tick out
);
  scu_unit_s q;
  scu_unit_s d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    d.cnt = 2'h0;
    unique case (port.ratio)
      SCU_OFF: d.tick = 1'b0;
      SCU_FULL: d.tick = 1'b1;
      SCU_HALF: begin
        d.tick = (q.cnt == 2'h0);
        d.cnt = (q.cnt == 2'h0) ? 2'h1 : 2'h0;
      end
      SCU_THIRD: begin
        d.tick = (q.cnt == 2'h0);
        // Out-of-range count after a ratio change wraps at once
        d.cnt = (q.cnt >= 2'h2) ? 2'h0 : q.cnt + 2'h1;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign port.tick = q.tick;

  ////////////////////////////////////////////////////////////////////////////
  property p_unit_off;
    @(posedge clk_i) disable iff (rst_i)
    (port.ratio == SCU_OFF) [*2] |-> !port.tick;
  endproperty
  a_unit_off: assert property (p_unit_off) else $error("unit tick while off");

  property p_unit_third;
    @(posedge clk_i) disable iff (rst_i)
    (port.ratio == SCU_THIRD) [*3] ##0 port.tick |=> !port.tick;
  endproperty
  a_unit_third: assert property (p_unit_third) else $error("third rate ticks back to back");
endmodule // scu_unit_div

// file: src/scu_unit_if.sv
// Ratio and tick between the clock unit and one unit clock divider.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface scu_unit_if;
  import scu_pkg::*;
  scu_ratio_e ratio;
  logic tick;
  modport ctrl (output ratio, input tick);
  modport unit (input ratio, output tick);
endinterface

// file: verif/scu_agent_model.sv
// Far-side agent that receives the three bus clocks.
// Assumes clocks are judged in simulation time; counts rises, keeps shortest high phase.
`timescale 1ns/1ps
module scu_agent_model (
  input wire logic [2:0] bus_clk_i,  // Bus clocks from the unit
  output logic [15:0] rise_cnt_o [3], // Rising edges per clock
  output logic [15:0] min_high_o [3]  // Shortest high phase in ns
);
  for (genvar i = 0; i < 3; i++) begin : g_pin
    realtime t_rise;
    initial begin
      rise_cnt_o[i] = 16'h0;
      min_high_o[i] = 16'hFFFF;
    end
    always @(posedge bus_clk_i[i]) begin
      rise_cnt_o[i] <= rise_cnt_o[i] + 16'h1;
      t_rise = $realtime;
    end
    // a runt high phase shows here
    always @(negedge bus_clk_i[i]) begin
      if (rise_cnt_o[i] != 16'h0 && $realtime - t_rise < min_high_o[i])
        min_high_o[i] <= 16'($rtoi($realtime - t_rise));
    end
  end
endmodule // scu_agent_model

// file: verif/tb.sv
// Self-checking bench of the clock configuration unit: three config word
// sets, register bus tasks and waveform counts. Assumes the register map header.
`timescale 1ns/1ps
`include "scu_regs.svh"
module tb;
  import scu_pkg::*;
  logic clk_i = 0, rst_i = 1, strap = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [31:0] lo = '0, hi = '0, wd = '0, rd;
  logic [7:0] awa = '0, ara = '0;
  logic awr, wr_rdy, bv, arr, rv, sync, memory_bus_clock, mckn, local_bus_clock_out, rsv, host, done;
  logic [1:0] br, rr, rsp, ediv;
  logic [2:0] bclk;
  logic [3:0] ratio, uen;
  logic [6:0] core;
  logic [4:0] memr, lbcr, emul;
  logic [15:0] rise [3], mh [3], r0, rz;
  int n_errors = 0, checks = 0, bad, tog [6], hi_n [4];
  always #4 clk_i = ~clk_i;
  scu_top DUT (.clk_i(clk_i), .rst_i(rst_i), .reset_config_word_low_i(lo), .reset_config_word_high_i(hi),
    .input_halving_strap_i(strap), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_rdy),
    .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_araddr_i(ara),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .sync_clock_out_o(sync), .bus_clock_out_o(bclk),
    .memory_bus_clock_o(memory_bus_clock), .memory_bus_clock_n_o(mckn), .local_bus_clock_out_o(local_bus_clock_out),
    .system_bus_ratio_o(ratio), .core_ratio_field_o(core), .memory_ctrl_ratio_o(memr),
    .local_bus_ctrl_ratio_o(lbcr), .engine_pll_multiplier_o(emul), .engine_pll_divisor_o(ediv),
    .system_pll_reserved_o(rsv), .host_mode_o(host), .config_done_o(done), .unit_clock_enable_o(uen));
  scu_agent_model AGT (.bus_clk_i(bclk), .rise_cnt_o(rise), .min_high_o(mh));
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    rsp = 2'h3;
    // Waits for the answer; only the watchdog ends a hang
    do begin
      @(posedge clk_i);
      if (awr) awv <= 0;
      if (wr_rdy) wv <= 0;
    end while (bv !== 1'b1);
    rsp = br;
    bry <= 0;
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    ara <= a;
    arv <= 1;
    rry <= 1;
    rsp = 2'h3;
    d = '1;
    do begin
      @(posedge clk_i);
      if (arr) arv <= 0;
    end while (rv !== 1'b1);
    d = rd;
    rsp = rr;
    rry <= 0;
  endtask
  // Toggle counts settle regardless of start phase over whole periods
  task automatic measure(input int n);
    logic [5:0] p, c;
    #1;
    p = {local_bus_clock_out, sync, memory_bus_clock, bclk};
    r0 = rise[0];
    tog = '{default: 0};
    hi_n = '{default: 0};
    bad = 0;
    repeat (n) begin
      @(posedge clk_i);
      #1;
      c = {local_bus_clock_out, sync, memory_bus_clock, bclk};
      for (int i = 0; i < 6; i++) tog[i] += int'(c[i] != p[i]);
      for (int i = 0; i < 4; i++) hi_n[i] += int'(uen[i] === 1'b1);
      bad += int'(memory_bus_clock === mckn) + int'(bclk[0] !== bclk[2]);
      p = c;
    end
    rz = rise[0] - r0;
  endtask
  task automatic do_reset(input logic s, input logic [31:0] l, input logic [31:0] h);
    @(posedge clk_i);
    rst_i <= 1;
    strap <= s;
    lo <= l;
    hi <= h;
    repeat (2) @(posedge clk_i);
    #1;
    chk("reset clocks", 32'h1, {bclk, sync, mckn});
    @(posedge clk_i);
    rst_i <= 0;
    while (done !== 1'b1) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
  endtask
  ////////////////////////////////////////
  initial begin
    #100000;
    n_errors++;
    end_of_test();
  end
  initial begin
    logic s;
    logic rs;
    logic [31:0] l, h, d, st;
    logic [3:0] m;
    logic [4:0] ra;
    int sy;
    logic cs [3] = '{1'b1, 1'b0, 1'b1};
    logic [31:0] cl [3] = '{32'h33852, 32'h01106, 32'h00007};
    logic [31:0] ch [3] = '{32'h1, 32'h1, 32'h0};
    for (int i = 0; i < 3; i++) begin
      s = cs[i];
      l = cl[i];
      h = ch[i];
      do_reset(s, l, h);
      m = l[3:0];
      rs = m < 4'h2 || m > 4'h6;
      ra = rs ? 5'h0 : 5'(m * (s ? 1 : 2));
      sy = h[0] ? (s ? 16 : 8) : 0;
      chk("host", h[0], host);
      chk("bus ratio", ra, ratio);
      chk("reserved", rs, rsv);
      chk("core", l[10:4], core);
      chk("mem ratio", 2 * ra, memr);
      chk("lbc ratio", ra << l[17], lbcr);
      chk("eng mult", l[15:11], emul);
      chk("eng div", 1 + l[16], ediv);
      st = {9'h0, 5'(ra << l[17]), 2'(1 + l[16]), l[15:11], ra[3:0], 3'h0, rs, s, h[0], 1'b1};
      rdr(`SCU_STAT_OFS, d);
      chk("status", st, d);
      chk("status resp", `SCU_RESP_OKAY, rsp);
      rdr(`SCU_RESET_CONFIG_WORD_LOW_OFS, d);
      chk("low word", l, d);
      rdr(`SCU_OUTPUT_CLOCK_CONTROL_REG_OFS, d);
      chk("output_clock_control_reg rst", `SCU_OUTPUT_CLOCK_CONTROL_REG_RST, d);
      rdr(`SCU_SYSTEM_CLOCK_CONTROL_REG_OFS, d);
      chk("system_clock_control_reg rst", `SCU_SYSTEM_CLOCK_CONTROL_REG_RST, d);
      measure(16);
      chk("bus idle", 0, tog[0] + tog[1] + tog[2]);
      chk("sync", sy, tog[4]);
      chk("mck", 16, tog[3]);
      chk("mck pair", 0, bad);
      for (int u = 0; u < 4; u++) chk("unit full", 16, hi_n[u]);
      wr(`SCU_OUTPUT_CLOCK_CONTROL_REG_OFS, 32'h5);
      chk("wr resp", `SCU_RESP_OKAY, rsp);
      repeat (4) @(posedge clk_i);
      measure(16);
      chk("bus0", sy, tog[0]);
      chk("bus1 off", 0, tog[1]);
      chk("bus2", sy, tog[2]);
      chk("aligned", 0, bad);
      chk("agent rises", sy / 2, rz);
      wr(`SCU_OUTPUT_CLOCK_CONTROL_REG_OFS, 32'h0);
      repeat (4) @(posedge clk_i);
      measure(16);
      chk("bus stop", 0, {bclk, 8'(tog[0] + tog[2])});
      wr(`SCU_SYSTEM_CLOCK_CONTROL_REG_OFS, 32'hE4);
      repeat (3) @(posedge clk_i);
      measure(12);
      chk("unit ticks", {8'd4, 8'd6, 8'd12, 8'd0}, {8'(hi_n[3]), 8'(hi_n[2]), 8'(hi_n[1]), 8'(hi_n[0])});
      for (int c = 0; c < 4; c++) begin
        wr(`SCU_LOCAL_BUS_CLOCK_RATIO_REG_OFS, c);
        repeat (4) @(posedge clk_i);
        measure(16);
        chk("local_bus_clock_out", 16 >> (c == 3 ? 2 : c), tog[5]);
      end
      rdr(8'h18, d);
      chk("unmapped rd", 32'h0, d);
      chk("unmapped rd resp", `SCU_RESP_SLVERR, rsp);
      wr(8'h18, 32'h1);
      chk("unmapped wr", `SCU_RESP_SLVERR, rsp);
    end
    chk("min high", 2'h3, {mh[0] >= 16'd8, mh[2] >= 16'd8});
    end_of_test();
  end
endmodule // tb
